// ===== rtl/asp_spi_slave.sv
/*
 * Serial slave of the angle encoder: streams zero-corrected angles,
 * takes register writes and reads, and requests one-time burns.
 * Assumes a mode-3 master (clock and select idle high), an OTP macro
 * whose outputs are static after power-up, and the master's select
 * setup of 50 ns, which covers the buffer freeze crossing.
 */
`timescale 1ns/1ps
`default_nettype none

module asp_spi_slave
    import asp_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       reset_i,
    input  wire logic       spi_sclk_i,
    input  wire logic       spi_cs_n_i,
    input  wire logic       spi_mosi_i,
    output logic            spi_miso_o,
    output logic            spi_miso_oe_o,
    input  wire logic       phase_cross_i,
    input  wire logic       otp_valid_i,
    input  wire logic [7:0] otp_zero_i,
    output logic            otp_burn_o,
    output logic [7:0]      otp_burn_data_o
);

    // Reference-clock domain state
    typedef struct packed {
        logic       cs_s1;
        logic       cs_s2;
        logic       done_s1;
        logic       done_s2;
        logic       done_s3;
        logic       otpv_s1;
        logic       otpv_s2;
        logic [7:0] otpz_s1;
        logic [7:0] otpz_s2;
        asp_boot_t  boot;
        logic [7:0] refresh_cnt;
        logic [7:0] raw_hold;
        logic [7:0] zero;
        logic [7:0] burn;
        logic       burned;
        asp_snap_t  snap;
        logic       burn_pulse;
        logic [7:0] burn_data;
    } asp_ref_state_t;

    // Link receive side, rising edges of the serial clock
    typedef struct packed {
        logic [4:0]  cnt;
        logic [14:0] rx;
        logic        done;
    } asp_rx_state_t;

    // Link transmit side, falling edges of the serial clock
    typedef struct packed {
        logic [6:0] sh;
        logic       miso;
        logic       oe;
    } asp_tx_state_t;

    asp_ref_state_t rf_r;
    asp_ref_state_t rf_nxt;
    asp_rx_state_t  rx_r;
    asp_rx_state_t  rx_nxt;
    asp_tx_state_t  tx_r;
    asp_tx_state_t  tx_nxt;
    asp_word_t      word_r;
    asp_word_t      word_nxt;
    logic [7:0]     frontend_angle;
    logic           angle_valid;

    asp_frontend u_frontend (
        .ref_clk_i        (ref_clk_i),
        .reset_i          (reset_i),
        .phase_cross_i    (phase_cross_i),
        .frontend_angle_o (frontend_angle),
        .angle_valid_o    (angle_valid)
    );

    // Receive shifter. Select high clears the frame state, since the
    // serial clock stands still between frames.
    always_comb
    begin
        rx_nxt   = rx_r;
        word_nxt = word_r;
        if (rx_r.cnt != FRAME_BITS)
        begin
            rx_nxt.rx  = {rx_r.rx[13:0], spi_mosi_i};
            rx_nxt.cnt = rx_r.cnt + 5'h01;
        end
        if (rx_r.cnt == LAST_BIT_CNT)
        begin
            word_nxt    = {rx_r.rx, spi_mosi_i};
            rx_nxt.done = 1'b1;
        end
    end

    always_ff @(posedge spi_sclk_i or posedge spi_cs_n_i)
    begin
        if (spi_cs_n_i)
        begin
            rx_r <= '0;
        end
        else
        begin
            rx_r <= rx_nxt;
        end
    end

    // Word holder has no reset: it is only read after done is seen,
    // and it stays put until the next frame's sixteenth bit.
    always_ff @(posedge spi_sclk_i)
    begin
        word_r <= word_nxt;
    end

    // Transmit: angle byte first, then register or zero byte
    always_comb
    begin
        logic [7:0] second;
        second = 8'h00;
        tx_nxt = tx_r;
        tx_nxt.oe = 1'b1;
        if (rx_r.rx[7:4] == CMD_READ)
        begin
            second = asp_reg_read(rf_r.snap, rx_r.rx[3:0]);
        end
        if (rx_r.cnt == 5'h00)
        begin
            tx_nxt.miso = rf_r.snap.angle[7];
            tx_nxt.sh   = rf_r.snap.angle[6:0];
        end
        else if (rx_r.cnt == FIRST_BYTE_CNT)
        begin
            tx_nxt.miso = second[7];
            tx_nxt.sh   = second[6:0];
        end
        else
        begin
            tx_nxt.miso = tx_r.sh[6];
            tx_nxt.sh   = {tx_r.sh[5:0], 1'b0};
        end
    end

    // Snapshot is frozen while selected, so this read is stable
    always_ff @(negedge spi_sclk_i or posedge spi_cs_n_i)
    begin
        if (spi_cs_n_i)
        begin
            tx_r <= '0;
        end
        else
        begin
            tx_r <= tx_nxt;
        end
    end

    // Reference domain: boot load, register writes, output buffer
    always_comb
    begin
        asp_word_t w;
        logic      event_seen;
        w          = word_r;
        rf_nxt     = rf_r;
        event_seen = 1'b0;

        rf_nxt.cs_s1   = spi_cs_n_i;
        rf_nxt.cs_s2   = rf_r.cs_s1;
        rf_nxt.done_s1 = rx_r.done;
        rf_nxt.done_s2 = rf_r.done_s1;
        rf_nxt.done_s3 = rf_r.done_s2;
        rf_nxt.otpv_s1 = otp_valid_i;
        rf_nxt.otpv_s2 = rf_r.otpv_s1;
        rf_nxt.otpz_s1 = otp_zero_i;
        rf_nxt.otpz_s2 = rf_r.otpz_s1;
        rf_nxt.burn_pulse = 1'b0;

        case (rf_r.boot)
            ST_SYNC0:
            begin
                rf_nxt.boot = ST_SYNC1;
            end
            ST_SYNC1:
            begin
                rf_nxt.boot = ST_LOAD;
            end
            ST_LOAD:
            begin
                // Burned contents replace the cleared value
                if (rf_r.otpv_s2)
                begin
                    rf_nxt.zero   = rf_r.otpz_s2;
                    rf_nxt.burned = 1'b1;
                end
                rf_nxt.boot = ST_RUN;
            end
            ST_RUN:
            begin
                event_seen = rf_r.done_s2 && !rf_r.done_s3;
            end
            default:
            begin
                rf_nxt.boot = ST_SYNC0;
            end
        endcase

        // Frames finishing during boot are dropped
        if (event_seen && w.cmd == CMD_WRITE)
        begin
            if (w.addr == ADDR_ZERO && !rf_r.burned)
            begin
                rf_nxt.zero = w.value;
            end
            else if (w.addr == ADDR_BURN)
            begin
                rf_nxt.burn = w.value;
                if (w.value[BURN_REG4_POS] && !rf_r.burned)
                begin
                    rf_nxt.burned     = 1'b1;
                    rf_nxt.burn_pulse = 1'b1;
                    rf_nxt.burn_data  = rf_r.zero;
                end
            end
        end

        // Raw sample taken into the buffer every refresh period
        if (rf_r.refresh_cnt == 8'(BUF_REFRESH_CYC - 1))
        begin
            rf_nxt.refresh_cnt = 8'h00;
            rf_nxt.raw_hold    = frontend_angle;
        end
        else
        begin
            rf_nxt.refresh_cnt = rf_r.refresh_cnt + 8'h01;
        end

        // Offset applied on the fly so a new zero shows at once.
        // Subtraction wraps modulo a full turn.
        if (rf_r.cs_s2)
        begin
            rf_nxt.snap.angle = rf_nxt.raw_hold - rf_nxt.zero;
            rf_nxt.snap.zero  = rf_nxt.zero;
            rf_nxt.snap.burn  = rf_nxt.burn;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            rf_r           <= '0;
            rf_r.cs_s1     <= 1'b1;
            rf_r.cs_s2     <= 1'b1;
            rf_r.boot      <= ST_SYNC0;
            rf_r.zero      <= ZERO_RST;
            rf_r.burn      <= BURN_RST;
        end
        else
        begin
            rf_r <= rf_nxt;
        end
    end

    assign spi_miso_o      = tx_r.miso;
    assign spi_miso_oe_o   = tx_r.oe;
    assign otp_burn_o      = rf_r.burn_pulse;
    assign otp_burn_data_o = rf_r.burn_data;

endmodule : asp_spi_slave

`default_nettype wire

// ===== rtl/asp_pkg.sv
/*
 * Shared constants, carriers and decode helpers for the angle sensor
 * serial slave and its front end.
 * Assumes a 125 MHz reference clock and a mode-3 serial master.
 */
package asp_pkg;

    // Clock and refresh timing
    localparam int unsigned REF_CLK_MHZ     = 125;
    localparam int unsigned FE_RATE_KHZ     = 500;
    localparam int unsigned FE_PERIOD_CYC   = REF_CLK_MHZ * 1000 / FE_RATE_KHZ;
    localparam int unsigned BUF_REFRESH_NS  = 2000;
    localparam int unsigned BUF_REFRESH_CYC =
        (BUF_REFRESH_NS * REF_CLK_MHZ) / 1000;

    // Frame layout
    localparam logic [4:0] LAST_BIT_CNT   = 5'h0f;
    localparam logic [4:0] FIRST_BYTE_CNT = 5'h08;
    localparam logic [4:0] FRAME_BITS     = 5'h10;

    // Command codes and register addresses
    localparam logic [3:0] CMD_READ  = 4'h1;
    localparam logic [3:0] CMD_WRITE = 4'h2;
    localparam logic [3:0] ADDR_ZERO = 4'h4;
    localparam logic [3:0] ADDR_BURN = 4'h9;

    // Reset values and field positions
    localparam logic [7:0] ZERO_RST      = 8'h00;
    localparam logic [7:0] BURN_RST      = 8'h00;
    localparam int unsigned BURN_REG4_POS = 4;

    typedef struct packed {
        logic [3:0] cmd;
        logic [3:0] addr;
        logic [7:0] value;
    } asp_word_t;

    typedef struct packed {
        logic [7:0] angle;
        logic [7:0] zero;
        logic [7:0] burn;
    } asp_snap_t;

    typedef enum logic [1:0] {
        ST_SYNC0 = 2'b00,
        ST_SYNC1 = 2'b01,
        ST_LOAD  = 2'b10,
        ST_RUN   = 2'b11
    } asp_boot_t;

    // Register read mux; unmapped addresses read as zero
    function automatic logic [7:0] asp_reg_read(
        input asp_snap_t  snap,
        input logic [3:0] addr
    );
        logic [7:0] val;
        val = 8'h00;
        if (addr == ADDR_ZERO)
        begin
            val = snap.zero;
        end
        else if (addr == ADDR_BURN)
        begin
            val = snap.burn;
        end
        return val;
    endfunction : asp_reg_read

endpackage : asp_pkg

// ===== rtl/asp_frontend.sv
/*
 * Time-to-digital front end: measures the delay from a fixed reference
 * edge to the phase signal's zero crossing and scales it to 8 bits.
 * Assumes phase_cross_i is a digital comparator output, asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none

module asp_frontend
    import asp_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       reset_i,
    input  wire logic       phase_cross_i,
    output logic [7:0]      frontend_angle_o,
    output logic            angle_valid_o
);

    typedef struct packed {
        logic       ph_s1;
        logic       ph_s2;
        logic       ph_s3;
        logic [1:0] fill;
        logic [7:0] period_cnt;
        logic [7:0] angle;
        logic       valid;
    } asp_fe_state_t;

    asp_fe_state_t st_r;
    asp_fe_state_t st_nxt;
    logic [15:0]   scaled;

    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.ph_s1 = phase_cross_i;
        st_nxt.ph_s2 = st_r.ph_s1;
        st_nxt.ph_s3 = st_r.ph_s2;
        st_nxt.valid = 1'b0;
        // Stages hold reset zeros at first: no false crossing at start
        if (st_r.fill != 2'h3)
        begin
            st_nxt.fill = st_r.fill + 2'h1;
        end
        // Fixed reference edge at count zero, no loop back into it
        if (st_r.period_cnt == 8'(FE_PERIOD_CYC - 1))
        begin
            st_nxt.period_cnt = 8'h00;
        end
        else
        begin
            st_nxt.period_cnt = st_r.period_cnt + 8'h01;
        end
        // Count of cycles since the reference edge, scaled to a turn
        scaled = {st_r.period_cnt, 8'h00} / 16'(FE_PERIOD_CYC);
        if (st_r.ph_s2 && !st_r.ph_s3 && st_r.fill == 2'h3)
        begin
            st_nxt.angle = scaled[7:0];
            st_nxt.valid = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign frontend_angle_o = st_r.angle;
    assign angle_valid_o    = st_r.valid;

endmodule : asp_frontend

`default_nettype wire

// ===== test/asp_monitor.sv
/* Port checker for asp_spi_slave.
   Assumes the reference clock domain and the bind below. */
`timescale 1ns/1ps
`default_nettype none
module asp_monitor (
    input wire logic       ref_clk_i,
    input wire logic       reset_i,
    input wire logic       spi_sclk_i,
    input wire logic       spi_cs_n_i,
    input wire logic       spi_miso_o,
    input wire logic       spi_miso_oe_o,
    input wire logic       otp_burn_o,
    input wire logic [7:0] otp_burn_data_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);
    sequence s_gap;
        ##1 !otp_burn_o;
    endsequence
    sequence s_boot;
        (!otp_burn_o && otp_burn_data_o == 8'h00) [*3];
    endsequence
    sequence s_held;
        (spi_miso_oe_o && !spi_cs_n_i) ##1 !spi_cs_n_i;
    endsequence
    property p_cs_idle;
        spi_cs_n_i |-> !spi_miso_oe_o && !spi_miso_o;
    endproperty
    a_cs_idle: assert property (p_cs_idle) else $error("drive idle");
    property p_oe_rise;
        $rose(spi_miso_oe_o) |-> !spi_cs_n_i && !spi_sclk_i;
    endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("oe rise");
    property p_oe_hold;
        s_held |-> spi_miso_oe_o;
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("oe drop");
    property p_miso_edge;
        $changed(spi_miso_o) && !spi_cs_n_i && !$past(spi_cs_n_i)
            |-> !spi_sclk_i;
    endproperty
    a_miso_edge: assert property (p_miso_edge) else $error("miso");
    property p_cs_wait;
        $fell(spi_cs_n_i) |-> (!spi_miso_oe_o) [*4];
    endproperty
    a_cs_wait: assert property (p_cs_wait) else $error("oe early");
    property p_burn_pulse;
        otp_burn_o |-> s_gap;
    endproperty
    a_burn_pulse: assert property (p_burn_pulse) else $error("burn");
    property p_data_hold;
        $changed(otp_burn_data_o) |-> otp_burn_o;
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data");
    property p_boot;
        $fell(reset_i) |-> s_boot;
    endproperty
    a_boot: assert property (p_boot) else $error("boot");
endmodule : asp_monitor
bind asp_spi_slave asp_monitor mon_u (
    .ref_clk_i      (ref_clk_i),
    .reset_i        (reset_i),
    .spi_sclk_i     (spi_sclk_i),
    .spi_cs_n_i     (spi_cs_n_i),
    .spi_miso_o     (spi_miso_o),
    .spi_miso_oe_o  (spi_miso_oe_o),
    .otp_burn_o     (otp_burn_o),
    .otp_burn_data_o(otp_burn_data_o)
);
`default_nettype wire

// ===== test/asp_spi_master_model.sv
/* Mode-3 serial master model, one 16-bit frame per go request.
   Assumes a free link clock; sclk stands high outside frames. */
`timescale 1ns/1ps
`default_nettype none
module asp_spi_master_model (
    input  wire logic        lclk_i,
    input  wire logic        go_i,
    input  wire logic [15:0] tx_i,
    input  wire logic        miso_i,
    output logic             sclk_o,
    output logic             cs_n_o,
    output logic             mosi_o,
    output logic [15:0]      rx_o,
    output logic             busy_o
);
    initial
    begin
        sclk_o = 1'b1;
        cs_n_o = 1'b0;
        mosi_o = 1'b0;
        rx_o   = 16'h0000;
        busy_o = 1'b0;
        // One select rise at start clears the slave's link flops
        #2 cs_n_o = 1'b1;
        forever
        begin
            @(posedge lclk_i);
            // Idle data toggles so no stale bit looks valid
            mosi_o <= ~mosi_o;
            if (go_i === 1'b1)
            begin
                busy_o <= 1'b1;
                cs_n_o <= 1'b0;
                repeat (2) @(posedge lclk_i);
                for (int i = 15; i >= 0; i--)
                begin
                    sclk_o <= 1'b0;
                    mosi_o <= tx_i[i];
                    @(posedge lclk_i);
                    sclk_o  <= 1'b1;
                    rx_o[i] <= miso_i;
                    @(posedge lclk_i);
                end
                repeat (2) @(posedge lclk_i);
                cs_n_o <= 1'b1;
                repeat (2) @(posedge lclk_i);
                busy_o <= 1'b0;
            end
        end
    end
endmodule : asp_spi_master_model
`default_nettype wire

// ===== test/asp_spi_slave_tb.sv
/* Self-checking bench for asp_spi_slave with a serial master model.
   Assumes a steady phase input, so the raw angle stays constant. */
`timescale 1ns/1ps
`default_nettype none
module asp_spi_slave_tb
    import asp_pkg::*;
;
    logic        ref_clk_i = 1'b0;
    logic        lclk      = 1'b0;
    logic        reset_i   = 1'b1;
    logic        phase     = 1'b0;
    logic        otp_valid = 1'b0;
    logic [7:0]  otp_zero  = 8'h00;
    logic        go        = 1'b0;
    logic [15:0] tx        = 16'h0000;
    logic        sclk, cs_n, mosi, miso, oe, burn, busy;
    logic [7:0]  bdata, a0;
    logic [7:0]  burn_cnt  = 8'h00;
    logic [7:0]  burn_seen = 8'h00;
    logic [15:0] rx, r;
    int          n_mismatch  = 0;
    int          check_count = 0;
    int          cyc         = 0;

    always #4 ref_clk_i = ~ref_clk_i;
    initial
    begin
        #1.3;
        forever #16 lclk = ~lclk;
    end

    asp_spi_master_model mst_u (.lclk_i(lclk), .go_i(go), .tx_i(tx),
        .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
        .rx_o(rx), .busy_o(busy));
    asp_spi_slave dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
        .spi_miso_o(miso), .spi_miso_oe_o(oe), .phase_cross_i(phase),
        .otp_valid_i(otp_valid), .otp_zero_i(otp_zero),
        .otp_burn_o(burn), .otp_burn_data_o(bdata));

    always @(posedge ref_clk_i)
    begin
        cyc <= cyc + 1;
        phase <= #1 ((cyc % 250) < 100);
        if (burn === 1'b1)
        begin
            burn_cnt  <= burn_cnt + 8'h01;
            burn_seen <= bdata;
        end
        if (cyc == 20000)
        begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: %h not %h", $time, seen, exp);
        end
    endtask : chk

    task automatic xfer(input logic [15:0] w);
        int i;
        @(posedge ref_clk_i);
        #1 tx = w;
        go = 1'b1;
        for (i = 0; i < 100 && busy !== 1'b1; i++) @(posedge ref_clk_i);
        chk({7'h00, busy}, 8'h01);
        #1 go = 1'b0;
        for (i = 0; i < 400 && busy !== 1'b0; i++) @(posedge ref_clk_i);
        chk({7'h00, busy}, 8'h00);
        r = rx;
    endtask : xfer

    task automatic rd(input logic [3:0] a);
        xfer({CMD_READ, a, 8'h00});
    endtask : rd

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        xfer({CMD_WRITE, a, v});
        chk(r[7:0], 8'h00);
    endtask : wr

    task automatic do_reset();
        @(posedge ref_clk_i);
        #1 reset_i = 1'b1;
        repeat (3) @(posedge ref_clk_i);
        #1 reset_i = 1'b0;
        // Two refresh periods, so the buffer holds a measured angle
        repeat (2 * BUF_REFRESH_CYC + 10) @(posedge ref_clk_i);
    endtask : do_reset

    task automatic t_defaults();
        rd(ADDR_ZERO);
        a0 = r[15:8];
        // Phase edge lands on count 249 of 250: 249 * 256 / 250
        chk(a0, 8'hfe);
        chk(r[7:0], ZERO_RST);
        rd(ADDR_BURN);
        chk(r[7:0], 8'h00);
        rd(4'h3);
        chk(r[7:0], 8'h00);
        chk(r[15:8], a0);
    endtask : t_defaults

    task automatic t_zero();
        wr(ADDR_ZERO, 8'hc0);
        rd(ADDR_ZERO);
        chk(r[15:8], a0 - 8'hc0);
        chk(r[7:0], 8'hc0);
        xfer({4'h3, ADDR_ZERO, 8'h11});
        wr(4'h5, 8'h77);
        rd(ADDR_ZERO);
        chk(r[7:0], 8'hc0);
    endtask : t_zero

    task automatic t_burn();
        wr(ADDR_BURN, 8'hef);
        repeat (10) @(posedge ref_clk_i);
        chk(burn_cnt, 8'h00);
        wr(ADDR_BURN, 8'h10);
        repeat (10) @(posedge ref_clk_i);
        chk(burn_cnt, 8'h01);
        chk(burn_seen, 8'hc0);
        wr(ADDR_ZERO, 8'h55);
        rd(ADDR_ZERO);
        chk(r[7:0], 8'hc0);
        rd(ADDR_BURN);
        chk(r[7:0], 8'h10);
    endtask : t_burn

    task automatic t_otp();
        @(posedge ref_clk_i);
        #1 otp_valid = 1'b1;
        otp_zero  = 8'h5a;
        do_reset();
        rd(ADDR_ZERO);
        chk(r[7:0], 8'h5a);
        wr(ADDR_ZERO, 8'h01);
        rd(ADDR_ZERO);
        chk(r[7:0], 8'h5a);
        chk(burn_cnt, 8'h01);
    endtask : t_otp

    task automatic finish_test();
        if (n_mismatch == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    initial
    begin
        do_reset();
        t_defaults();
        t_zero();
        t_burn();
        t_otp();
        finish_test();
    end
endmodule : asp_spi_slave_tb
`default_nettype wire
